//--- rtl/sif_top.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module sif_top import sif_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic mode_sw_closed_i,
  input wire logic inhibit_sel0_closed_i,
  input wire logic sel1_closed_i,
  input wire logic sel2_closed_i,
  input wire logic cmd_pulse_i,
  input wire logic adc_valid_i,
  input wire logic [SMP_W-1:0] adc_data_i,
  output logic [1:0] active_mode_o,
  output logic cmd_pulse_o,
  output logic [2:0] speed_code_o,
  output logic speed_code_valid_o,
  output logic [SMP_W-1:0] velocity_cmd_o,
  output logic velocity_cmd_valid_o,
  output logic [SMP_W-1:0] speed_limit_o,
  output logic speed_limit_valid_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [SMP_W-1:0] sat16(input logic signed [33:0] v);
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    hi = 34'sh7FFF;
    lo = -34'sh8000;
    if (v > hi) begin
      sat16 = 16'h7FFF;
    end else if (v < lo) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[SMP_W-1:0];
    end
  endfunction

  function automatic logic [SMP_W-1:0] neg16(input logic [SMP_W-1:0] v);
    neg16 = sat16(-{{18{v[SMP_W-1]}}, v});
  endfunction

  // ------------------------------------------------------------
  // Settings
  // ------------------------------------------------------------
  logic [2:0] ctrl_mode_r;
  logic inh_en_r;
  logic trq_sel_r;
  logic [15:0] gain_r;
  logic reverse_r;
  logic [15:0] offset_r;
  logic [3:0] filter_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ctrl_mode_r <= RST_CTRL_MODE;
      inh_en_r <= RST_INH_EN;
      trq_sel_r <= RST_TRQ_SEL;
      gain_r <= RST_GAIN;
      reverse_r <= RST_REVERSE;
      offset_r <= RST_OFFSET;
      filter_r <= RST_FILTER;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL_MODE: ctrl_mode_r <= reg_wdata_i[2:0];
        REG_INH_EN: inh_en_r <= reg_wdata_i[0];
        REG_TRQ_SEL: trq_sel_r <= reg_wdata_i[0];
        REG_GAIN: gain_r <= reg_wdata_i[15:0];
        REG_REVERSE: reverse_r <= reg_wdata_i[0];
        REG_OFFSET: offset_r <= reg_wdata_i[15:0];
        REG_FILTER: filter_r <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic pulse_d_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pulse_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {cmd_pulse_i, sel2_closed_i, sel1_closed_i,
                   inhibit_sel0_closed_i, mode_sw_closed_i};
      pin_s2_r <= pin_s1_r;
      pulse_d_r <= pin_s2_r[4];
    end
  end

  logic mode_sw_s;
  logic inh_s;
  logic sel1_s;
  logic sel2_s;
  logic pulse_rise;

  assign mode_sw_s = pin_s2_r[0];
  assign inh_s = pin_s2_r[1];
  assign sel1_s = pin_s2_r[2];
  assign sel2_s = pin_s2_r[3];
  assign pulse_rise = pin_s2_r[4] & ~pulse_d_r;

  // ------------------------------------------------------------
  // Active control mode
  // ------------------------------------------------------------
  sif_act_t act_nxt;
  sif_act_t act_r;

  always_comb begin
    act_nxt = ACT_NONE;
    unique case (ctrl_mode_r)
      CM_POS: act_nxt = ACT_POS;
      CM_VEL: act_nxt = ACT_VEL;
      CM_TRQ: act_nxt = ACT_TRQ;
      CM_POS_VEL: act_nxt = mode_sw_s ? ACT_VEL : ACT_POS;
      CM_POS_TRQ: act_nxt = mode_sw_s ? ACT_TRQ : ACT_POS;
      CM_VEL_TRQ: act_nxt = mode_sw_s ? ACT_TRQ : ACT_VEL;
      default: act_nxt = ACT_NONE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      act_r <= ACT_NONE;
    end else begin
      act_r <= act_nxt;
    end
  end

  assign active_mode_o = act_r;

  // ------------------------------------------------------------
  // Position pulse gate
  // ------------------------------------------------------------
  logic pulse_ok;
  logic [DATA_W-1:0] pulse_cnt_r;

  assign pulse_ok = (act_r == ACT_POS) && (inh_en_r || inh_s);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cmd_pulse_o <= 1'b0;
      pulse_cnt_r <= '0;
    end else begin
      cmd_pulse_o <= pulse_rise && pulse_ok;
      if (pulse_rise && pulse_ok) begin
        pulse_cnt_r <= pulse_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Internal speed selection
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      speed_code_o <= 3'h0;
      speed_code_valid_o <= 1'b0;
    end else if (act_r == ACT_VEL) begin
      speed_code_o <= {sel2_s, sel1_s, inh_s};
      speed_code_valid_o <= 1'b1;
    end else begin
      speed_code_o <= 3'h0;
      speed_code_valid_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Analog speed input conditioning
  // ------------------------------------------------------------
  logic [SMP_W-1:0] offs_r;
  logic offs_vld_r;
  logic [SMP_W-1:0] scaled_r;
  logic scaled_vld_r;
  logic [SMP_W-1:0] filt_r;
  logic signed [33:0] offs_sum;
  logic signed [33:0] prod;
  logic signed [33:0] step;

  assign offs_sum = 34'(signed'(adc_data_i)) + 34'(signed'(offset_r));
  assign prod = (34'(signed'(offs_r)) * 34'(signed'(gain_r))) >>> GAIN_FRAC;
  assign step = (34'(signed'(scaled_r)) - 34'(signed'(filt_r))) >>> filter_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      offs_r <= 16'h0000;
      offs_vld_r <= 1'b0;
      scaled_r <= 16'h0000;
      scaled_vld_r <= 1'b0;
      filt_r <= 16'h0000;
    end else begin
      offs_vld_r <= adc_valid_i;
      scaled_vld_r <= offs_vld_r;
      if (adc_valid_i) begin
        offs_r <= sat16(offs_sum);
      end
      if (offs_vld_r) begin
        scaled_r <= sat16(prod);
      end
      if (scaled_vld_r) begin
        filt_r <= sat16(34'(signed'(filt_r)) + step);
      end
    end
  end

  // ------------------------------------------------------------
  // Velocity command and speed limit routing
  // ------------------------------------------------------------
  logic vel_use;
  logic lim_use;

  assign vel_use = (act_r == ACT_VEL) && ((ctrl_mode_r == CM_VEL)
                   || (ctrl_mode_r == CM_POS_VEL) || (ctrl_mode_r == CM_VEL_TRQ));
  assign lim_use = (act_r == ACT_TRQ) && (ctrl_mode_r == CM_VEL_TRQ)
                   && trq_sel_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      velocity_cmd_o <= 16'h0000;
      velocity_cmd_valid_o <= 1'b0;
    end else if (vel_use) begin
      velocity_cmd_o <= reverse_r ? neg16(filt_r) : filt_r;
      velocity_cmd_valid_o <= 1'b1;
    end else begin
      velocity_cmd_o <= 16'h0000;
      velocity_cmd_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      speed_limit_o <= 16'h0000;
      speed_limit_valid_o <= 1'b0;
    end else if (lim_use) begin
      speed_limit_o <= filt_r;
      speed_limit_valid_o <= 1'b1;
    end else begin
      speed_limit_o <= 16'h0000;
      speed_limit_valid_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rd_nxt;

  always_comb begin
    rd_nxt = '0;
    unique case (reg_addr_i)
      REG_CTRL_MODE: rd_nxt[2:0] = ctrl_mode_r;
      REG_INH_EN: rd_nxt[0] = inh_en_r;
      REG_TRQ_SEL: rd_nxt[0] = trq_sel_r;
      REG_GAIN: rd_nxt[15:0] = gain_r;
      REG_REVERSE: rd_nxt[0] = reverse_r;
      REG_OFFSET: rd_nxt[15:0] = offset_r;
      REG_FILTER: rd_nxt[3:0] = filter_r;
      REG_STATUS: begin
        rd_nxt[STAT_MODE_LSB +: 2] = act_r;
        rd_nxt[STAT_CODE_LSB +: 3] = speed_code_o;
        rd_nxt[STAT_LIM_BIT] = speed_limit_valid_o;
        rd_nxt[STAT_VEL_BIT] = velocity_cmd_valid_o;
      end
      REG_VEL_CMD: rd_nxt[15:0] = velocity_cmd_o;
      REG_SPD_LIM: rd_nxt[15:0] = speed_limit_o;
      REG_PULSE_CNT: rd_nxt = pulse_cnt_r;
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule // sif_top

//--- include/sif_pkg.sv
// Function
// - Switch input open selects first, closed second
// - Position: open inhibit input drops command pulses
// - Inhibit setting 0 makes inhibit input effective
// - Velocity: input is bit of 3-bit speed code
// - Settings 1,3,5 velocity use analog speed command
// - Command conditioned by gain, reversal, offset, filter
// - Torque selection 0 ignores analog in torque
// - Torque selection 1 uses analog as limit; the code does this in setting 5 only, not in settings 2 and 4
// - Limit uses gain, offset, filter, no reversal
// - Analog sample is 16-bit signed result
// - Switching mode: function only in its mode
package sif_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL_MODE = 8'h00;
  localparam logic [7:0] REG_INH_EN = 8'h04;
  localparam logic [7:0] REG_TRQ_SEL = 8'h08;
  localparam logic [7:0] REG_GAIN = 8'h0C;
  localparam logic [7:0] REG_REVERSE = 8'h10;
  localparam logic [7:0] REG_OFFSET = 8'h14;
  localparam logic [7:0] REG_FILTER = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_VEL_CMD = 8'h20;
  localparam logic [7:0] REG_SPD_LIM = 8'h24;
  localparam logic [7:0] REG_PULSE_CNT = 8'h28;

  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [2:0] RST_CTRL_MODE = 3'h0;
  localparam logic RST_INH_EN = 1'b1;
  localparam logic RST_TRQ_SEL = 1'b0;
  localparam logic [15:0] RST_GAIN = 16'h0100;
  localparam logic RST_REVERSE = 1'b0;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [3:0] RST_FILTER = 4'h0;
  localparam int GAIN_FRAC = 8;
  localparam int SMP_W = 16;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_CODE_LSB = 4;
  localparam int STAT_LIM_BIT = 8;
  localparam int STAT_VEL_BIT = 9;

  // ------------------------------------------------------------
  // Control mode settings
  // ------------------------------------------------------------
  localparam logic [2:0] CM_POS = 3'h0;
  localparam logic [2:0] CM_VEL = 3'h1;
  localparam logic [2:0] CM_TRQ = 3'h2;
  localparam logic [2:0] CM_POS_VEL = 3'h3;
  localparam logic [2:0] CM_POS_TRQ = 3'h4;
  localparam logic [2:0] CM_VEL_TRQ = 3'h5;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_POS,
    ACT_VEL,
    ACT_TRQ
  } sif_act_t;

endpackage

//--- bench/sif_top_asserts.sv
`timescale 1ns/1ps
module sif_chk import sif_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_pulse_i,
  input wire logic [1:0] active_mode_o,
  input wire logic cmd_pulse_o,
  input wire logic [2:0] speed_code_o,
  input wire logic speed_code_valid_o,
  input wire logic [SMP_W-1:0] velocity_cmd_o,
  input wire logic velocity_cmd_valid_o,
  input wire logic [SMP_W-1:0] speed_limit_o,
  input wire logic speed_limit_valid_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_out;
    cmd_pulse_o;
  endsequence
  sequence s_pin;
    $past(cmd_pulse_i, 3);
  endsequence
  property p_pulse_cause; s_out |-> s_pin; endproperty
  property p_pulse_pos; s_out |-> $past(active_mode_o) == ACT_POS; endproperty
  property p_pulse_one; s_out |=> !cmd_pulse_o; endproperty
  property p_vel_mode; velocity_cmd_valid_o |-> $past(active_mode_o) == ACT_VEL; endproperty
  property p_vel_zero; !velocity_cmd_valid_o |-> velocity_cmd_o == 16'h0000; endproperty
  property p_code_zero; !speed_code_valid_o |-> speed_code_o == 3'h0; endproperty
  property p_lim_mode; speed_limit_valid_o |-> $past(active_mode_o) == ACT_TRQ; endproperty
  property p_lim_zero; !speed_limit_valid_o |-> speed_limit_o == 16'h0000; endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without pin");
  a_pulse_pos: assert property (p_pulse_pos) else $error("pulse outside position");
  a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
  a_vel_mode: assert property (p_vel_mode) else $error("velocity outside mode");
  a_vel_zero: assert property (p_vel_zero) else $error("velocity not zero");
  a_code_zero: assert property (p_code_zero) else $error("code not zero");
  a_lim_mode: assert property (p_lim_mode) else $error("limit outside torque");
  a_lim_zero: assert property (p_lim_zero) else $error("limit not zero");
endmodule // sif_chk

bind sif_top sif_chk i_sif_chk (.ref_clk_i, .rst_b_i, .cmd_pulse_i, .active_mode_o,
  .cmd_pulse_o, .speed_code_o, .speed_code_valid_o, .velocity_cmd_o,
  .velocity_cmd_valid_o, .speed_limit_o, .speed_limit_valid_o);

//--- bench/sif_host.sv
`timescale 1ns/1ps
module sif_host (
  input wire logic ref_clk_i,
  input wire logic pulse_req_i,
  output logic pin_o
);
  logic [3:0] cnt_r = 4'h0;
  // Pulse high 4 cycles then low 4 cycles
  always_ff @(posedge ref_clk_i) begin
    if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    else if (pulse_req_i) cnt_r <= 4'h8;
  end
  assign pin_o = cnt_r > 4'h4;
endmodule // sif_host

//--- bench/sif_top_test.sv
`timescale 1ns/1ps
module sif_top_test import sif_pkg::*; ;
  logic clk, rst_b, wr, rd, sw, s0, s1, s2, req, pin, av, po, scv, vcv, slv;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, rdata;
  logic [SMP_W-1:0] ad, vc, sl;
  logic [1:0] am;
  logic [2:0] sc;
  int error_cnt = 0, cmp_count = 0, pulses = 0;
  sif_top i_sif_top (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .mode_sw_closed_i(sw),
    .inhibit_sel0_closed_i(s0), .sel1_closed_i(s1), .sel2_closed_i(s2), .cmd_pulse_i(pin),
    .adc_valid_i(av), .adc_data_i(ad), .active_mode_o(am), .cmd_pulse_o(po),
    .speed_code_o(sc), .speed_code_valid_o(scv), .velocity_cmd_o(vc),
    .velocity_cmd_valid_o(vcv), .speed_limit_o(sl), .speed_limit_valid_o(slv));
  sif_host i_sif_host (.ref_clk_i(clk), .pulse_req_i(req), .pin_o(pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (po === 1'b1) pulses++;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic pulse(input int e);
    int p0;
    p0 = pulses;
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
    wt(14);
    chk("pulses", e, pulses - p0);
  endtask
  task automatic smp(input logic [15:0] d);
    @(posedge clk) begin av <= 1'b1; ad <= d; end
    @(posedge clk) av <= 1'b0;
    wt(6);
  endtask
  task automatic pins(input logic m, input logic [2:0] c);
    @(posedge clk) begin sw <= m; {s2, s1, s0} <= c; end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_pos();
    rchk("inh_en", REG_INH_EN, 32'h1);
    rchk("gain", REG_GAIN, 32'h100);
    rchk("unmapped", 8'h30, 32'h0);
    pulse(1);
    wreg(REG_INH_EN, 32'h0);
    pulse(0);
    pins(1'b0, 3'h1);
    pulse(1);
    wreg(REG_PULSE_CNT, 32'h0);
    rchk("count", REG_PULSE_CNT, 32'h2);
  endtask
  task automatic t_vel();
    wreg(REG_CTRL_MODE, CM_VEL);
    wreg(REG_GAIN, 32'h200);
    wreg(REG_OFFSET, 32'h10);
    pins(1'b0, 3'h5);
    smp(16'h0100);
    chk("code", 3'h5, sc);
    chk("code_v", 1'b1, scv);
    chk("vel", 16'h0220, vc);
    pulse(0);
    wreg(REG_REVERSE, 32'h1);
    smp(16'hFF00);
    chk("vel_neg", 16'h01E0, vc);
  endtask
  task automatic t_trq();
    wreg(REG_CTRL_MODE, CM_TRQ);
    smp(16'h0100);
    chk("mode", ACT_TRQ, am);
    chk("code", 3'h0, sc);
    chk("code_v", 1'b0, scv);
    chk("vel_v", 1'b0, vcv);
    pulse(0);
  endtask
  task automatic t_swt();
    wreg(REG_CTRL_MODE, CM_VEL_TRQ);
    smp(16'h0100);
    chk("mode", ACT_VEL, am);
    chk("vel", 16'hFDE0, vc);
    pins(1'b1, 3'h5);
    smp(16'h0100);
    chk("mode", ACT_TRQ, am);
    chk("lim_v", 1'b0, slv);
    chk("lim0", 16'h0000, sl);
    wreg(REG_TRQ_SEL, 32'h1);
    smp(16'h0100);
    chk("lim", 16'h0220, sl);
    chk("lim_v", 1'b1, slv);
    rchk("lim_reg", REG_SPD_LIM, 32'h220);
    wreg(REG_CTRL_MODE, CM_POS_VEL);
    wt(6);
    chk("mode", ACT_VEL, am);
    pins(1'b0, 3'h5);
    wt(6);
    chk("mode", ACT_POS, am);
    wreg(REG_CTRL_MODE, CM_POS_TRQ);
    pins(1'b1, 3'h5);
    wt(6);
    chk("mode", ACT_TRQ, am);
  endtask
  task automatic t_flt();
    wreg(REG_CTRL_MODE, CM_VEL);
    wreg(REG_REVERSE, 32'h0);
    wreg(REG_GAIN, 32'h100);
    wreg(REG_OFFSET, 32'h0);
    wreg(REG_FILTER, 32'h1);
    rchk("filter", REG_FILTER, 32'h1);
    smp(16'h0020);
    chk("vel_f1", 16'h0120, vc);
    smp(16'h0020);
    chk("vel_f2", 16'h00A0, vc);
    rchk("vel_reg", REG_VEL_CMD, 32'hA0);
    rchk("status", REG_STATUS, 32'h252);
    wreg(REG_CTRL_MODE, 32'h6);
    smp(16'h0020);
    chk("mode", ACT_NONE, am);
    chk("vel_v", 1'b0, vcv);
    pulse(0);
  endtask
  task automatic t_rst();
    @(posedge clk) rst_b <= 1'b0;
    wt(2);
    rst_b <= 1'b1;
    rchk("mode_rst", REG_CTRL_MODE, 32'h0);
    rchk("inh_rst", REG_INH_EN, 32'h1);
    rchk("filt_rst", REG_FILTER, 32'h0);
    pulse(1);
    rchk("cnt_rst", REG_PULSE_CNT, 32'h1);
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {rst_b, wr, rd, sw, s0, s1, s2, req, av} = '0;
    addr = '0; wd = '0; ad = '0;
    wt(5);
    rst_b <= 1'b1;
    t_pos();
    t_vel();
    t_trq();
    t_swt();
    t_flt();
    t_rst();
    finish_test();
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule // sif_top_test
